// ==== common/clkdist_pkg.sv ====
package clkdist_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_IO_UPDATE  = 14'h0005;
  localparam logic [13:0] IDX_MFPIN_EN   = 14'h0200;
  localparam logic [13:0] IDX_CHG_PUMP   = 14'h0400;
  localparam logic [13:0] IDX_CAL        = 14'h0405;
  localparam logic [13:0] IDX_RF_DIV     = 14'h0407;
  localparam logic [13:0] IDX_SYNC_CTRL  = 14'h0500;
  localparam logic [13:0] IDX_CFG_A      = 14'h0501;
  localparam logic [13:0] IDX_DIVLO_A    = 14'h0502;
  localparam logic [13:0] IDX_DIVHI_A    = 14'h0503;
  localparam logic [13:0] IDX_CFG_B      = 14'h0504;
  localparam logic [13:0] IDX_DIVLO_B    = 14'h0505;
  localparam logic [13:0] IDX_DIVHI_B    = 14'h0506;
  localparam logic [13:0] IDX_LOOP_MODE  = 14'h0a01;
  localparam logic [13:0] IDX_STATUS     = 14'h0d01;

  ////////////////////////////////////////////////////////////////////////
  // Storage slots of staged and active copies
  localparam int unsigned SLOT_MFPIN   = 0;
  localparam int unsigned SLOT_CP      = 1;
  localparam int unsigned SLOT_CAL     = 2;
  localparam int unsigned SLOT_RF      = 3;
  localparam int unsigned SLOT_SYNC    = 4;
  localparam int unsigned SLOT_CFG_A   = 5;
  localparam int unsigned SLOT_DIVLO_A = 6;
  localparam int unsigned SLOT_DIVHI_A = 7;
  localparam int unsigned SLOT_CFG_B   = 8;
  localparam int unsigned SLOT_DIVLO_B = 9;
  localparam int unsigned SLOT_DIVHI_B = 10;
  localparam int unsigned SLOT_LOOP    = 11;
  localparam int unsigned NUM_SLOTS    = 12;
  localparam int unsigned SLOTS_PER_CH = 3;

  ////////////////////////////////////////////////////////////////////////
  // Field positions and codes
  localparam int unsigned UPDATE_BIT      = 0;
  localparam logic [7:0]  MFPIN_ON        = 8'h01;
  localparam int unsigned CAL_START_BIT   = 0;
  localparam int unsigned CAL_UNGATE_BIT  = 3;
  localparam logic [3:0]  RF_RESET_CODE   = 4'hf;
  localparam int unsigned RF_A_LSB        = 0;
  localparam int unsigned RF_B_LSB        = 4;
  localparam int unsigned SYNC_SEL_LSB    = 0;
  localparam int unsigned SYNC_DIRECT_BIT = 2;
  localparam int unsigned SYNC_MASK_LSB   = 4;
  localparam int unsigned CFG_PD_BIT      = 0;
  localparam int unsigned CFG_EN_BIT      = 1;
  localparam int unsigned CFG_POL_BIT     = 2;
  localparam int unsigned CFG_DRV_BIT     = 3;
  localparam int unsigned CFG_FMT_LSB     = 4;
  localparam int unsigned DIVHI_PHASE_LSB = 2;
  localparam int unsigned STAT_DL_BIT     = 0;
  localparam int unsigned STAT_BUSY_BIT   = 1;
  localparam int unsigned STAT_OPLL_BIT   = 2;
  localparam logic [7:0]  SYNC_OPCODE     = 8'ha1;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h02;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CAL_TIME_NS   = 100000;
  localparam int unsigned CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SRC_PIN, SRC_DL_LOCK, SRC_REF_EDGE, SRC_MFPIN} sync_src_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_t;

endpackage

// ==== verification/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [15:0] adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 16'h0000;
    sel_o = 4'h1;
    dat_o = 32'h0;
  end

  // No answer time is assumed; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'h0};
    dat_o <= {24'h0, wd};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released address and data lines never keep the last value
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    logic [31:0] unused;
    xfer(1'b1, idx, wd, unused);
  endtask

  task automatic rd(input logic [13:0] idx, output logic [31:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask

  task automatic upd();
    wr(clkdist_pkg::IDX_IO_UPDATE, 8'h01);
  endtask

  task automatic calibrate();
    wr(clkdist_pkg::IDX_LOOP_MODE, 8'h20);
    upd();
    wr(clkdist_pkg::IDX_CAL, 8'h20);
    upd();
    wr(clkdist_pkg::IDX_CAL, 8'h21);
    upd();
  endtask

  // Parking first avoids a runt when the ratio changes without calibration
  task automatic rf_change(input logic [7:0] ratios);
    wr(clkdist_pkg::IDX_RF_DIV, 8'hff);
    upd();
    wr(clkdist_pkg::IDX_RF_DIV, ratios);
    upd();
  endtask
endmodule
`default_nettype wire

// ==== verification/output_clock_distribution_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module output_clock_distribution_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Outputs
  input wire logic        output_pll_cal_o,
  input wire logic        cmos_out_o,
  input wire logic [1:0]  cmos_family_o,
  input wire logic        diff_out_p_o,
  input wire logic        diff_out_n_o,
  input wire logic        diff_powered_o,
  input wire logic [1:0]  diff_family_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counts calibration length; a stuck counter in the design shows here
  logic [11:0] cal_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !output_pll_cal_o) begin
      cal_cnt <= 12'h000;
    end else begin
      cal_cnt <= cal_cnt + 12'h001;
    end
  end

  ack_next_cycle_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !cmos_out_o && !diff_out_p_o
    && dat_o == 32'h0) else $error("outputs not quiet after reset");
  cal_hold_a: assert property ($rose(output_pll_cal_o) |-> output_pll_cal_o[*8])
    else $error("calibration too short");
  cal_long_a: assert property (cal_cnt <= 12'h3f2)
    else $error("calibration never ends");
  cal_short_a: assert property ($fell(output_pll_cal_o) |-> cal_cnt >= 12'h3de)
    else $error("calibration ended early");
  cal_static_a: assert property (output_pll_cal_o[*3] |-> $stable(cmos_out_o)
    && $stable(diff_out_p_o)) else $error("clock moved during calibration");
  diff_off_a: assert property (!diff_powered_o[*2] |-> !diff_out_p_o && !diff_out_n_o)
    else $error("powered down pair drives");
  diff_pair_a: assert property (diff_out_p_o |-> !diff_out_n_o)
    else $error("pair not complementary");
  family_codes_a: assert property (!cmos_family_o[1] && diff_family_o != 2'h3)
    else $error("illegal family code");
endmodule

bind output_clock_distribution output_clock_distribution_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .output_pll_cal_o(output_pll_cal_o), .cmos_out_o(cmos_out_o), .cmos_family_o(cmos_family_o),
  .diff_out_p_o(diff_out_p_o), .diff_out_n_o(diff_out_n_o), .diff_powered_o(diff_powered_o),
  .diff_family_o(diff_family_o));
`default_nettype wire

// ==== verification/output_clock_distribution_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module output_clock_distribution_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, pll_lock = 1'b0, ee_valid = 1'b0;
  logic [15:0] adr;
  logic [3:0]  sel, n;
  logic [31:0] wdat, rdat, rd;
  logic [7:0]  ee_byte = 8'h00, cp_o, mode_o, cp, m;
  logic        cal_o, cmos_out, cmos_pwr, cmos_drv, diff_p, diff_n, diff_pwr, diff_drv;
  logic [1:0]  cmos_fam, diff_fam;
  int          seed = 65018;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;

  host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  output_clock_distribution dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .output_pll_lock_i(pll_lock), .digital_loop_locked_i(1'b0), .ref_clk_i(1'b0),
    .sync_pin_i(1'b0), .mf_pin_i(1'b0), .eeprom_valid_i(ee_valid), .eeprom_byte_i(ee_byte),
    .output_pll_cp_o(cp_o), .output_pll_cal_o(cal_o), .digital_loop_mode_o(mode_o),
    .cmos_out_o(cmos_out), .cmos_powered_o(cmos_pwr), .cmos_drive_low_o(cmos_drv),
    .cmos_family_o(cmos_fam), .diff_out_p_o(diff_p), .diff_out_n_o(diff_n),
    .diff_powered_o(diff_pwr), .diff_drive_low_o(diff_drv), .diff_family_o(diff_fam));

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Skips the partial period, then counts one low and one high phase
  task automatic measure(input logic [31:0] half, input logic same_b);
    logic [31:0] hi, lo;
    hi = 0;
    lo = 0;
    while (cmos_out !== 1'b1) @(posedge clk_i);
    while (cmos_out === 1'b1) @(posedge clk_i);
    while (cmos_out !== 1'b1) begin
      lo++;
      @(posedge clk_i);
    end
    if (same_b) check_pin(diff_p, 1'b1);
    while (cmos_out === 1'b1) begin
      hi++;
      @(posedge clk_i);
    end
    check_reg(hi, half);
    check_reg(lo, half);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    host.rd(clkdist_pkg::IDX_STATUS, rd);
    check_reg(rd, 32'h0);
    host.rd(clkdist_pkg::IDX_CFG_A, rd);
    check_reg(rd, 32'(clkdist_pkg::RST_CFG));
    host.rd(14'h0100, rd);
    check_reg(rd, 32'h0);
    cp = 8'($random(seed));
    host.wr(clkdist_pkg::IDX_CHG_PUMP, cp);
    repeat (3) @(posedge clk_i);
    check_reg(32'(cp_o), 32'h0);
    host.rd(clkdist_pkg::IDX_CHG_PUMP, rd);
    check_reg(rd, 32'(cp));
    host.upd();
    repeat (4) @(posedge clk_i);
    check_reg(32'(cp_o), 32'(cp));
    pll_lock <= 1'b1;
    host.calibrate();
    while (cal_o !== 1'b1) @(posedge clk_i);
    check_reg(32'(mode_o), 32'h20);
    while (cal_o === 1'b1) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    host.rd(clkdist_pkg::IDX_STATUS, rd);
    check_pin(rd[2], 1'b1);
    check_pin(cmos_out, 1'b0);
    check_pin(diff_p, 1'b0);
    for (int it = 0; it < 2; it++) begin
      n = 4'(2 + $unsigned($random(seed)) % 2);
      m = 8'(4 + $unsigned($random(seed)) % 3);
      host.wr(clkdist_pkg::IDX_DIVLO_A, m);
      host.wr(clkdist_pkg::IDX_DIVLO_B, m);
      if (it == 0) begin
        host.wr(clkdist_pkg::IDX_RF_DIV, {n, n});
        host.upd();
      end else begin
        host.rf_change({n + 4'h1, n});
      end
      host.wr(clkdist_pkg::IDX_SYNC_CTRL, 8'h04);
      host.upd();
      measure(32'(n) * 32'(m), it == 0);
    end
    // A storage sync opcode in a high phase must restart low
    while (cmos_out !== 1'b1) @(posedge clk_i);
    ee_byte  <= clkdist_pkg::SYNC_OPCODE;
    ee_valid <= 1'b1;
    @(posedge clk_i);
    ee_valid <= 1'b0;
    repeat (4) @(posedge clk_i);
    check_pin(cmos_out, 1'b0);
    for (int f = 0; f < 3; f++) begin
      host.wr(clkdist_pkg::IDX_CFG_A, 8'(8'h0a | ((f % 2) << 4)));
      host.wr(clkdist_pkg::IDX_CFG_B, 8'(8'h02 | (f << 4)));
      host.upd();
      repeat (4) @(posedge clk_i);
      check_reg(32'(cmos_fam), 32'(f % 2));
      check_reg(32'(diff_fam), 32'(f));
      check_pin(cmos_drv, 1'b1);
      check_pin(diff_drv, 1'b0);
      check_pin(diff_n, ~diff_p);
    end
    host.wr(clkdist_pkg::IDX_CFG_B, 8'h03);
    host.upd();
    repeat (4) @(posedge clk_i);
    check_pin(diff_pwr, 1'b0);
    check_pin(cmos_pwr, 1'b1);
    pll_lock <= 1'b0;
    repeat (6) @(posedge clk_i);
    host.rd(clkdist_pkg::IDX_STATUS, rd);
    check_pin(rd[2], 1'b0);
    // Lock lost: a sync in a high phase must not restart the divider
    while (cmos_out !== 1'b1) @(posedge clk_i);
    ee_valid <= 1'b1;
    @(posedge clk_i);
    ee_valid <= 1'b0;
    repeat (4) @(posedge clk_i);
    check_pin(cmos_out, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// ==== verilog/output_clock_distribution.sv ====
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: Host recalibrates output PLL on startup, frequency change.
// R2: Host ensures stable clock, free-run loop first.
// R3: Host writes 0x20, update, 0x21, update.
// R4: Staged writes apply only on update command.
// R5: Status bit 2 shows calibrated and locked.
// R6: RF ratios from low and high nibbles.
// R7: RF dividers keep 50% duty, any ratio.
// R8: Calibration resets the RF dividers.
// R9: Host parks divider at 0x0F before changing.
// R10: Ten-bit channel dividers, ratio 1..1023, 50% duty.
// R11: Each driver powers down on its own.
// R12: Enable changes only at period boundaries.
// R13: Per-channel family, drive, polarity, ratio, phase.
// R14: Channel families and CMOS drive strength settings.
// R15: Dividers stay static until first sync.
// R16: Selectable sync sources plus direct sync bit.
// R17: Storage opcode 0xA1 triggers direct sync.
// R18: Sync passes only with output PLL locked; the code also passes it when CAL bit 3 is set.
// R19: Masked channels ignore sync, start on lock.
// R20: Pin sync before pin enable emits auto sync.
// R21: Accepted sync restarts unmasked dividers together.
module output_clock_distribution (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Asynchronous status and sync inputs
  input  wire logic        output_pll_lock_i,
  input  wire logic        digital_loop_locked_i,
  input  wire logic        ref_clk_i,
  input  wire logic        sync_pin_i,
  input  wire logic        mf_pin_i,
  // Configuration download stream, same clock
  input  wire logic        eeprom_valid_i,
  input  wire logic [7:0]  eeprom_byte_i,
  // Output PLL control
  output logic      [7:0]  output_pll_cp_o,
  output logic             output_pll_cal_o,
  output logic      [7:0]  digital_loop_mode_o,
  // CMOS output channel
  output logic             cmos_out_o,
  output logic             cmos_powered_o,
  output logic             cmos_drive_low_o,
  output logic      [1:0]  cmos_family_o,
  // Differential output channel
  output logic             diff_out_p_o,
  output logic             diff_out_n_o,
  output logic             diff_powered_o,
  output logic             diff_drive_low_o,
  output logic      [1:0]  diff_family_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // {hit, slot} for a register index
  function automatic logic [4:0] decode(input logic [13:0] idx);
    logic [4:0] r;
    r = 5'h00;
    unique case (idx)
      clkdist_pkg::IDX_MFPIN_EN:  r = {1'b1, 4'(clkdist_pkg::SLOT_MFPIN)};
      clkdist_pkg::IDX_CHG_PUMP:  r = {1'b1, 4'(clkdist_pkg::SLOT_CP)};
      clkdist_pkg::IDX_CAL:       r = {1'b1, 4'(clkdist_pkg::SLOT_CAL)};
      clkdist_pkg::IDX_RF_DIV:    r = {1'b1, 4'(clkdist_pkg::SLOT_RF)};
      clkdist_pkg::IDX_SYNC_CTRL: r = {1'b1, 4'(clkdist_pkg::SLOT_SYNC)};
      clkdist_pkg::IDX_CFG_A:     r = {1'b1, 4'(clkdist_pkg::SLOT_CFG_A)};
      clkdist_pkg::IDX_DIVLO_A:   r = {1'b1, 4'(clkdist_pkg::SLOT_DIVLO_A)};
      clkdist_pkg::IDX_DIVHI_A:   r = {1'b1, 4'(clkdist_pkg::SLOT_DIVHI_A)};
      clkdist_pkg::IDX_CFG_B:     r = {1'b1, 4'(clkdist_pkg::SLOT_CFG_B)};
      clkdist_pkg::IDX_DIVLO_B:   r = {1'b1, 4'(clkdist_pkg::SLOT_DIVLO_B)};
      clkdist_pkg::IDX_DIVHI_B:   r = {1'b1, 4'(clkdist_pkg::SLOT_DIVHI_B)};
      clkdist_pkg::IDX_LOOP_MODE: r = {1'b1, 4'(clkdist_pkg::SLOT_LOOP)};
      default:                    r = 5'h00;
    endcase
    return r;
  endfunction

  // Zero ratio behaves as divide by one
  function automatic logic [9:0] last_count(input logic [9:0] ratio);
    return (ratio == 10'h000) ? 10'h000 : ratio - 10'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [7:0]  staged [clkdist_pkg::NUM_SLOTS];
  logic [7:0]  active [clkdist_pkg::NUM_SLOTS];
  logic [13:0] idx;
  logic [4:0]  dec;
  logic        bus_req;
  logic        bus_wr;
  logic        upd;
  logic [7:0]  status;

  assign idx     = adr_i[15:2];
  assign dec     = decode(idx);
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr  = bus_req & we_i & sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req & ~we_i) begin
      if (idx == clkdist_pkg::IDX_STATUS) begin
        dat_o <= {24'h00_0000, status};
      end else if (dec[4]) begin
        dat_o <= {24'h00_0000, staged[dec[3:0]]};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // Update command is a one-cycle pulse, nothing stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd <= 1'b0;
    end else begin
      upd <= bus_wr & (idx == clkdist_pkg::IDX_IO_UPDATE)
             & dat_i[clkdist_pkg::UPDATE_BIT]; // R4
    end
  end

  // Direct sync bit clears itself once applied; a host write in that cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < clkdist_pkg::NUM_SLOTS; i++) begin
        if (i == clkdist_pkg::SLOT_CFG_A || i == clkdist_pkg::SLOT_CFG_B) begin
          staged[i] <= clkdist_pkg::RST_CFG;
        end else begin
          staged[i] <= clkdist_pkg::RST_REG;
        end
      end
    end else begin
      if (upd) begin
        staged[clkdist_pkg::SLOT_SYNC][clkdist_pkg::SYNC_DIRECT_BIT] <= 1'b0;
      end
      if (bus_wr & dec[4]) begin
        staged[dec[3:0]] <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < clkdist_pkg::NUM_SLOTS; i++) begin
        if (i == clkdist_pkg::SLOT_CFG_A || i == clkdist_pkg::SLOT_CFG_B) begin
          active[i] <= clkdist_pkg::RST_CFG;
        end else begin
          active[i] <= clkdist_pkg::RST_REG;
        end
      end
    end else if (upd) begin
      for (int i = 0; i < clkdist_pkg::NUM_SLOTS; i++) begin
        active[i] <= staged[i]; // R4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic [4:0] pin_rise;
  logic       opll_lock_s;
  logic       dl_lock_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
    end else begin
      pin_meta <= {mf_pin_i, sync_pin_i, ref_clk_i, digital_loop_locked_i, output_pll_lock_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise    = pin_sync & ~pin_prev;
  assign opll_lock_s = pin_sync[0];
  assign dl_lock_s   = pin_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Output PLL calibration

  clkdist_pkg::cal_state_t cal_state;
  logic [9:0] cal_cnt;
  logic       cal_start;
  logic       opll_ok;
  logic       gate_open;

  // Only a 0 to 1 change of the start bit launches a run
  assign cal_start = upd & staged[clkdist_pkg::SLOT_CAL][clkdist_pkg::CAL_START_BIT]
                     & ~active[clkdist_pkg::SLOT_CAL][clkdist_pkg::CAL_START_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state <= clkdist_pkg::CAL_IDLE;
      cal_cnt   <= 10'h000;
    end else if (cal_start) begin
      cal_state <= clkdist_pkg::CAL_RUN;
      cal_cnt   <= 10'h000;
    end else begin
      unique case (cal_state)
        clkdist_pkg::CAL_IDLE: cal_cnt <= 10'h000;
        clkdist_pkg::CAL_RUN: begin
          if (cal_cnt == 10'(clkdist_pkg::CAL_CYCLES - 1)) begin
            cal_state <= clkdist_pkg::CAL_DONE;
          end else begin
            cal_cnt <= cal_cnt + 10'h001;
          end
        end
        clkdist_pkg::CAL_DONE: cal_cnt <= 10'h000;
      endcase
    end
  end

  assign opll_ok   = (cal_state == clkdist_pkg::CAL_DONE) & opll_lock_s; // R5
  assign gate_open = opll_ok
                     | active[clkdist_pkg::SLOT_CAL][clkdist_pkg::CAL_UNGATE_BIT]; // R18

  assign status = {5'h00,
                   opll_ok,
                   cal_state == clkdist_pkg::CAL_RUN,
                   dl_lock_s}; // R5

  ////////////////////////////////////////////////////////////////////////
  // Channel sync unit

  logic [1:0] sel_act;
  logic [1:0] sel_new;
  logic       mfpin_on;
  logic       src_evt;
  logic       auto_evt;
  logic       sync_evt;
  logic       sync_ok;

  assign sel_act  = active[clkdist_pkg::SLOT_SYNC][clkdist_pkg::SYNC_SEL_LSB +: 2];
  assign sel_new  = staged[clkdist_pkg::SLOT_SYNC][clkdist_pkg::SYNC_SEL_LSB +: 2];
  assign mfpin_on = active[clkdist_pkg::SLOT_MFPIN] == clkdist_pkg::MFPIN_ON;

  always_comb begin
    src_evt = 1'b0;
    unique case (clkdist_pkg::sync_src_t'(sel_act))
      clkdist_pkg::SRC_PIN:      src_evt = pin_rise[3];
      clkdist_pkg::SRC_DL_LOCK:  src_evt = pin_rise[1];
      clkdist_pkg::SRC_REF_EDGE: src_evt = pin_rise[2];
      clkdist_pkg::SRC_MFPIN:    src_evt = pin_rise[4] & mfpin_on;
    endcase
  end // R16

  // Pin function assigned before the pin enable took effect
  assign auto_evt = upd & (sel_new == 2'(clkdist_pkg::SRC_MFPIN))
                    & (sel_act != 2'(clkdist_pkg::SRC_MFPIN)) & ~mfpin_on; // R20

  assign sync_evt = src_evt | auto_evt
                    | (upd & staged[clkdist_pkg::SLOT_SYNC][clkdist_pkg::SYNC_DIRECT_BIT]) // R16
                    | (eeprom_valid_i & (eeprom_byte_i == clkdist_pkg::SYNC_OPCODE)); // R17
  assign sync_ok  = sync_evt & gate_open; // R18

  ////////////////////////////////////////////////////////////////////////
  // RF and channel dividers
  // One clock cycle is a half-period of the VCO model, so a ratio N
  // gives N cycles high and N low: exact 50% for odd ratios too.

  logic [3:0] rf_ratio [2];
  logic [9:0] ch_ratio [2];
  logic [9:0] ch_phase [2];
  logic [7:0] ch_cfg   [2];
  logic [1:0] ch_mask;
  logic [1:0] rf_tick;
  logic [3:0] rf_cnt   [2];
  logic [9:0] ch_cnt   [2];
  logic [1:0] running;
  logic [1:0] ch_lvl;
  logic [1:0] en_live;
  logic       rf_reset;

  assign rf_reset = cal_state == clkdist_pkg::CAL_RUN; // R8
  assign ch_mask  = active[clkdist_pkg::SLOT_SYNC][clkdist_pkg::SYNC_MASK_LSB +: 2];

  always_comb begin
    rf_ratio[0] = active[clkdist_pkg::SLOT_RF][clkdist_pkg::RF_A_LSB +: 4]; // R6
    rf_ratio[1] = active[clkdist_pkg::SLOT_RF][clkdist_pkg::RF_B_LSB +: 4]; // R6
    for (int c = 0; c < 2; c++) begin
      ch_cfg[c]   = active[clkdist_pkg::SLOT_CFG_A + clkdist_pkg::SLOTS_PER_CH * c];
      ch_ratio[c] = {active[clkdist_pkg::SLOT_DIVHI_A + clkdist_pkg::SLOTS_PER_CH * c][1:0],
                     active[clkdist_pkg::SLOT_DIVLO_A + clkdist_pkg::SLOTS_PER_CH * c]}; // R10
      ch_phase[c] = {4'h0,
                     active[clkdist_pkg::SLOT_DIVHI_A + clkdist_pkg::SLOTS_PER_CH * c]
                       [clkdist_pkg::DIVHI_PHASE_LSB +: 6]}; // R13
      rf_tick[c]  = (rf_ratio[c] != clkdist_pkg::RF_RESET_CODE) & ~rf_reset
                    & ({6'h00, rf_cnt[c]} == last_count({6'h00, rf_ratio[c]})); // R7
    end
  end

  // Parked code 0x0F and calibration both hold the RF divider in reset
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_i | rf_reset | (rf_ratio[c] == clkdist_pkg::RF_RESET_CODE)
          | (sync_ok & ~ch_mask[c]) | rf_tick[c]) begin
        rf_cnt[c] <= 4'h0; // R8
      end else begin
        rf_cnt[c] <= rf_cnt[c] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_i) begin
        running[c] <= 1'b0; // R15
        ch_cnt[c]  <= 10'h000;
        ch_lvl[c]  <= 1'b0;
        en_live[c] <= 1'b0;
      end else if (sync_ok & ~ch_mask[c]) begin
        running[c] <= 1'b1; // R21
        ch_cnt[c]  <= ch_phase[c];
        ch_lvl[c]  <= 1'b0;
      end else if (~running[c]) begin
        running[c] <= ch_mask[c] & gate_open; // R19
        en_live[c] <= 1'b0;
      end else if (rf_tick[c]) begin
        if (ch_cnt[c] >= last_count(ch_ratio[c])) begin
          ch_cnt[c] <= 10'h000;
          ch_lvl[c] <= ~ch_lvl[c]; // R10
          // Enable only changes as a new high phase starts: no runts
          if (~ch_lvl[c]) begin
            en_live[c] <= ch_cfg[c][clkdist_pkg::CFG_EN_BIT]; // R12
          end
        end else begin
          ch_cnt[c] <= ch_cnt[c] + 10'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drivers

  logic [1:0] drive;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      drive[c] = ~ch_cfg[c][clkdist_pkg::CFG_PD_BIT]
                 & ((running[c] & en_live[c] & ch_lvl[c])
                    ^ ch_cfg[c][clkdist_pkg::CFG_POL_BIT]); // R11 R13
    end
  end

  // Differential pair carries the complement; parked low when powered down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmos_out_o       <= 1'b0;
      cmos_powered_o   <= 1'b0;
      cmos_drive_low_o <= 1'b0;
      cmos_family_o    <= 2'h0;
      diff_out_p_o     <= 1'b0;
      diff_out_n_o     <= 1'b0;
      diff_powered_o   <= 1'b0;
      diff_drive_low_o <= 1'b0;
      diff_family_o    <= 2'h0;
    end else begin
      cmos_out_o       <= drive[0];
      cmos_powered_o   <= ~ch_cfg[0][clkdist_pkg::CFG_PD_BIT]; // R11
      cmos_drive_low_o <= ch_cfg[0][clkdist_pkg::CFG_DRV_BIT]; // R14
      cmos_family_o    <= {1'b0, ch_cfg[0][clkdist_pkg::CFG_FMT_LSB]}; // R14
      diff_out_p_o     <= drive[1];
      diff_out_n_o     <= ~ch_cfg[1][clkdist_pkg::CFG_PD_BIT] & ~drive[1];
      diff_powered_o   <= ~ch_cfg[1][clkdist_pkg::CFG_PD_BIT]; // R11
      diff_drive_low_o <= ch_cfg[1][clkdist_pkg::CFG_DRV_BIT]; // R14
      diff_family_o    <= (ch_cfg[1][clkdist_pkg::CFG_FMT_LSB +: 2] == 2'h3)
                          ? 2'h2 : ch_cfg[1][clkdist_pkg::CFG_FMT_LSB +: 2]; // R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_pll_cp_o     <= 8'h00;
      output_pll_cal_o    <= 1'b0;
      digital_loop_mode_o <= 8'h00;
    end else begin
      output_pll_cp_o     <= active[clkdist_pkg::SLOT_CP];
      output_pll_cal_o    <= rf_reset;
      digital_loop_mode_o <= active[clkdist_pkg::SLOT_LOOP];
    end
  end

endmodule

`default_nettype wire
